// ==== verilog/pad_bank_defs.svh ====
`ifndef PAD_BANK_DEFS_SVH
`define PAD_BANK_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PAD_IDX_PIN6 16'hf7a1
`define PAD_IDX_PIN7 16'hf7a2
`define PAD_IDX_CLK_OUT 16'hf7a3
`define PAD_IDX_PIN14 16'hf7a8
`define PAD_IDX_PIN15 16'hf7a9
`define PAD_IDX_SER0 16'hf7b0
`define PAD_IDX_SER7 16'hf7b7
`define PAD_IDX_PIN24 16'hf7b8
`define SOFT_IDX 16'hf890

// ----------------------------------------------------------------
// Storage entry numbers
// ----------------------------------------------------------------
`define PAD_COUNT 14
`define ENT_PIN6 0
`define ENT_PIN7 1
`define ENT_CLK_OUT 2
`define ENT_PIN14 3
`define ENT_PIN15 4
`define ENT_SER0 5
`define ENT_SER7 12
`define ENT_PIN24 13

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define PAD_RST_PULLDN 16'h0018
`define PAD_RST_CLK_OUT 16'h0008
`define PAD_RST_PIN24 16'h0018
`define SOFT_RST_VAL 16'h0001
`define PAD_MASK_FULL 16'hffff
`define PAD_MASK_LOW 16'h001f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PULL_BIT 4
`define SLEW_HI 3
`define SLEW_LO 2
`define DRIVE_HI 1
`define DRIVE_LO 0
`define RSVD_HI 15
`define RSVD_LO 5
`define SOFT_BIT 0

`endif

// ==== verilog/pad_bank_pkg.sv ====
`default_nettype none
`include "pad_bank_defs.svh"

package pad_bank_pkg;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // One pad configuration word
  typedef logic [15:0] pad_word_t;
  // Slew codes
  typedef enum logic [1:0] {
    slew_slowest = 2'h0,
    slew_slow = 2'h1,
    slew_fast = 2'h2,
    slew_fastest = 2'h3
  } slew_code_t;
  // Drive codes
  typedef enum logic [1:0] {
    drive_lowest = 2'h0,
    drive_low = 2'h1,
    drive_high = 2'h2,
    drive_highest = 2'h3
  } drive_code_t;
endpackage

`default_nettype wire

// ==== verilog/pad_cfg_if.sv ====
`default_nettype none
`include "pad_bank_defs.svh"

// Carries writes and soft clear to storage, stored words back
interface pad_cfg_if;
  logic wr_en; // Write strobe
  logic [3:0] wr_sel; // Entry being written
  pad_bank_pkg::pad_word_t wr_data; // Write data
  logic soft_clr; // Soft reset active
  pad_bank_pkg::pad_word_t regs [`PAD_COUNT]; // Stored words

  modport bus (
    output wr_en, wr_sel, wr_data, soft_clr,
    input regs
  );
  modport store (
    input wr_en, wr_sel, wr_data, soft_clr,
    output regs
  );
endinterface

`default_nettype wire

// ==== verilog/pad_cfg_store.sv ====
`default_nettype none
`include "pad_bank_defs.svh"

module pad_cfg_store (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, active low
  pad_cfg_if.store cfg // Storage side
);

  // ----------------------------------------------------------------
  // Per-entry defaults and writable masks
  // ----------------------------------------------------------------
  localparam logic [`PAD_COUNT-1:0][15:0] RST = {
    `PAD_RST_PIN24, {8{`PAD_RST_PULLDN}}, `PAD_RST_PULLDN,
    `PAD_RST_PULLDN, `PAD_RST_CLK_OUT, `PAD_RST_PULLDN,
    `PAD_RST_PULLDN};
  localparam logic [`PAD_COUNT-1:0][15:0] MASK = {
    {11{`PAD_MASK_LOW}}, {3{`PAD_MASK_FULL}}};

  // ----------------------------------------------------------------
  // Storage entries
  // ----------------------------------------------------------------
  for (genvar i = 0; i < `PAD_COUNT; i++) begin : g_ent
    // Soft clear beats a write; reserved bits masked off except in entries 0 to 2
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg.regs[i] <= RST[i];
      end else if (cfg.soft_clr) begin
        cfg.regs[i] <= RST[i];
      end else if (cfg.wr_en && cfg.wr_sel == 4'(i)) begin
        cfg.regs[i] <= cfg.wr_data & MASK[i];
      end
    end
  end

endmodule

`default_nettype wire

// ==== verilog/pad_control_register_bank.sv ====
`default_nettype none
`include "pad_bank_defs.svh"

module pad_control_register_bank (
  input wire logic pclk, // Core clock, 25 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high writes
  input wire logic [17:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic [`PAD_COUNT-1:0][1:0] pad_slew_code, // Per pad
  output logic [`PAD_COUNT-1:0][1:0] pad_drive_code, // Per pad
  output logic pin_six_pulldown_enable, // Pin six pull
  output logic pin_seven_pulldown_enable, // Pin seven pull
  output logic clock_output_pulldown_enable, // Clock pin pull
  output logic pin_fourteen_pulldown_enable, // Pin 14 pull
  output logic pin_fifteen_pulldown_enable, // Pin 15 pull
  output logic [7:0] serial_data_pulldown_enable, // Serial pulls
  output logic pin_twentyfour_pullup_enable // Pin 24 pull-up
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pad_cfg_if cfg (); // Link to storage
  logic [15:0] reg_idx; // Word index from address
  logic aligned; // Low address bits clear
  logic [`PAD_COUNT-1:0] hit; // One-hot entry match
  logic soft_hit; // Soft reset register match
  logic mapped; // Any register matches
  logic setup; // APB setup phase
  logic access; // APB access phase
  logic [3:0] sel; // Encoded entry number
  logic [15:0] rd_word; // Read mux output
  logic [15:0] soft_word; // Soft reset register

  // ----------------------------------------------------------------
  // Entry address table
  // ----------------------------------------------------------------
  // Index of a storage entry
  function automatic logic [15:0] entry_addr(input int e);
    logic [15:0] a;
    a = 16'h0000;
    if (e == `ENT_PIN6) begin
      a = `PAD_IDX_PIN6;
    end else if (e == `ENT_PIN7) begin
      a = `PAD_IDX_PIN7;
    end else if (e == `ENT_CLK_OUT) begin
      a = `PAD_IDX_CLK_OUT;
    end else if (e == `ENT_PIN14) begin
      a = `PAD_IDX_PIN14;
    end else if (e == `ENT_PIN15) begin
      a = `PAD_IDX_PIN15;
    end else if (e >= `ENT_SER0 && e <= `ENT_SER7) begin
      a = `PAD_IDX_SER0 + 16'(e - `ENT_SER0);
    end else if (e == `ENT_PIN24) begin
      a = `PAD_IDX_PIN24;
    end
    return a;
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Word index and alignment
  assign reg_idx = paddr[17:2];
  assign aligned = paddr[1:0] == 2'h0;

  // One comparator per entry
  for (genvar i = 0; i < `PAD_COUNT; i++) begin : g_hit
    assign hit[i] = aligned && (reg_idx == entry_addr(i));
  end

  // Soft reset register and overall match
  assign soft_hit = aligned && (reg_idx == `SOFT_IDX);
  assign mapped = (|hit) || soft_hit;

  // Encode the matching entry
  always_comb begin
    sel = 4'h0;
    for (int k = 0; k < `PAD_COUNT; k++) begin
      if (hit[k]) begin
        sel = 4'(k);
      end
    end
  end

  // Read mux, stored words only
  always_comb begin
    rd_word = 16'h0000;
    if (soft_hit) begin
      rd_word = soft_word;
    end else if (|hit) begin
      rd_word = cfg.regs[sel];
    end
  end

  // ----------------------------------------------------------------
  // APB phases
  // ----------------------------------------------------------------
  // Setup and access decode
  assign setup = psel && !penable;
  assign access = psel && penable;
  // Zero wait states: data is captured during setup
  assign pready = 1'b1;

  // Read data captured in setup, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      if (!pwrite) begin
        prdata <= {16'h0000, rd_word};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Unmapped or misaligned address answers with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !mapped;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  // Pad writes take effect at the access edge
  assign cfg.wr_en = access && pwrite && (|hit);
  assign cfg.wr_sel = sel;
  assign cfg.wr_data = pwdata[15:0];

  // Soft reset register, bit zero active low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_word <= `SOFT_RST_VAL;
    end else if (access && pwrite && soft_hit) begin
      soft_word <= pwdata[15:0];
    end
  end

  // Soft clear while bit zero is low
  assign cfg.soft_clr = !soft_word[`SOFT_BIT];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  pad_cfg_store store (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg.store)
  );

  // ----------------------------------------------------------------
  // Pad controls
  // ----------------------------------------------------------------
  // Slew and drive codes for every pad
  for (genvar i = 0; i < `PAD_COUNT; i++) begin : g_pad
    assign pad_slew_code[i] =
      cfg.regs[i][`SLEW_HI:`SLEW_LO];
    assign pad_drive_code[i] =
      cfg.regs[i][`DRIVE_HI:`DRIVE_LO];
  end

  // Pull resistor enables
  assign pin_six_pulldown_enable =
    cfg.regs[`ENT_PIN6][`PULL_BIT];
  assign pin_seven_pulldown_enable =
    cfg.regs[`ENT_PIN7][`PULL_BIT];
  assign clock_output_pulldown_enable =
    cfg.regs[`ENT_CLK_OUT][`PULL_BIT];
  assign pin_fourteen_pulldown_enable =
    cfg.regs[`ENT_PIN14][`PULL_BIT];
  assign pin_fifteen_pulldown_enable =
    cfg.regs[`ENT_PIN15][`PULL_BIT];
  for (genvar s = 0; s < 8; s++) begin : g_ser
    assign serial_data_pulldown_enable[s] =
      cfg.regs[`ENT_SER0 + s][`PULL_BIT];
  end
  assign pin_twentyfour_pullup_enable =
    cfg.regs[`ENT_PIN24][`PULL_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A committed write to one word index
  sequence wr_at(logic [15:0] a);
    access && pwrite && aligned && reg_idx == a && !cfg.soft_clr;
  endsequence

  // A read setup at one word index
  sequence rd_setup(logic [15:0] a);
    setup && !pwrite && aligned && reg_idx == a;
  endsequence

  // Soft clear held two cycles
  sequence soft_held;
    cfg.soft_clr [*2];
  endsequence

  // Slew codes all fast after soft clear
  slew_default_a: assert property (
    soft_held |-> pad_slew_code == {`PAD_COUNT{2'h2}})
    else $error("slew code not at default");

  // Drive codes all lowest after soft clear
  drive_default_a: assert property (
    soft_held |-> pad_drive_code == '0)
    else $error("drive code not at default");

  // Pin six pull-down on after soft clear
  pin_six_pull_a: assert property (
    cfg.soft_clr |=> pin_six_pulldown_enable)
    else $error("pin six pull-down not restored");

  // Pin seven write lands on its slew code and pull-down
  pin_seven_write_a: assert property (
    wr_at(`PAD_IDX_PIN7) |=>
      pad_slew_code[`ENT_PIN7] == $past(pwdata[3:2]) &&
      pin_seven_pulldown_enable == $past(pwdata[4]))
    else $error("pin seven write lost");

  // Clock pad reads back its default after soft clear
  clock_pad_read_a: assert property (
    cfg.soft_clr ##1
      rd_setup(`PAD_IDX_CLK_OUT) |=>
      prdata == {16'h0000, `PAD_RST_CLK_OUT})
    else $error("clock pad default wrong");

  // Pin fourteen write sets drive code
  pin_fourteen_write_a: assert property (
    wr_at(`PAD_IDX_PIN14) |=>
      pad_drive_code[`ENT_PIN14] == $past(pwdata[1:0]))
    else $error("pin fourteen write lost");

  // Pin fifteen write sets its pull-down
  pin_fifteen_write_a: assert property (
    wr_at(`PAD_IDX_PIN15) |=>
      pin_fifteen_pulldown_enable == $past(pwdata[4]))
    else $error("pin fifteen write lost");

  // Last serial pad decodes and stores
  serial_last_write_a: assert property (
    wr_at(`PAD_IDX_SER7) |=>
      serial_data_pulldown_enable[7] == $past(pwdata[4]) &&
      $stable(serial_data_pulldown_enable[6:0]))
    else $error("serial pad write misdecoded");

  // Pin twenty-four pull-up on after soft clear
  pin_24_pull_a: assert property (
    cfg.soft_clr |=> pin_twentyfour_pullup_enable)
    else $error("pin twenty-four pull-up not restored");

  // Reserved bits of later pads read zero
  reserved_zero_a: assert property (
    rd_setup(`PAD_IDX_SER0) or rd_setup(`PAD_IDX_PIN24) |=>
      prdata[`RSVD_HI:`RSVD_LO] == '0)
    else $error("reserved bits not zero");

  // Soft clear restores words within one cycle
  soft_restore_a: assert property (
    $rose(cfg.soft_clr) |=>
      cfg.regs[`ENT_PIN14] == `PAD_RST_PULLDN &&
      cfg.regs[`ENT_CLK_OUT] == `PAD_RST_CLK_OUT)
    else $error("soft clear did not restore");

  // Without write or clear, slew and drive codes hold
  pads_hold_a: assert property (
    !cfg.wr_en && !cfg.soft_clr |=>
      $stable(pad_slew_code) && $stable(pad_drive_code))
    else $error("pad settings changed unasked");

endmodule

`default_nettype wire

// ==== sim/pad_control_register_bank_test.sv ====
`default_nettype none
`include "pad_bank_defs.svh"

module pad_control_register_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0; // Core clock
  logic presetn = 1'b0; // Reset, active low
  logic psel = 1'b0; // APB select
  logic penable = 1'b0; // APB enable
  logic pwrite = 1'b0; // APB direction
  logic [17:0] paddr = 18'h0; // APB address
  logic [31:0] pwdata = 32'h0; // APB write data
  logic [31:0] prdata; // APB read data
  logic pready; // APB ready
  logic pslverr; // APB error
  logic [`PAD_COUNT-1:0][1:0] pad_slew_code; // Slew outputs
  logic [`PAD_COUNT-1:0][1:0] pad_drive_code; // Drive outputs
  logic pull6, pull7, pullck, pull14, pull15, pull24; // Pull outputs
  logic [7:0] pullser; // Serial pulls
  int miscompares = 0; // Mismatch count
  int comparisons = 0; // Compare count
  int cycles = 0; // Timeout counter
  logic [31:0] rd; // Last read data
  logic err; // Last error
  logic [31:0] wd; // Random write data

  pad_control_register_bank i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_slew_code(pad_slew_code),
    .pad_drive_code(pad_drive_code), .pin_six_pulldown_enable(pull6),
    .pin_seven_pulldown_enable(pull7),
    .clock_output_pulldown_enable(pullck),
    .pin_fourteen_pulldown_enable(pull14),
    .pin_fifteen_pulldown_enable(pull15),
    .serial_data_pulldown_enable(pullser),
    .pin_twentyfour_pullup_enable(pull24)
  );

  // Clock, 40 ns period
  always #20 pclk = ~pclk;

  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------
  // Word index of an entry
  function automatic logic [15:0] idx_of(input int e);
    case (e)
      0: return 16'hf7a1;
      1: return 16'hf7a2;
      2: return 16'hf7a3;
      3: return 16'hf7a8;
      4: return 16'hf7a9;
      13: return 16'hf7b8;
      default: return 16'hf7b0 + 16'(e - 5);
    endcase
  endfunction
  // Default word
  function automatic logic [15:0] rst_of(input int e);
    return (e == 2) ? 16'h0008 : 16'h0018;
  endfunction
  // Bits that hold what is written
  function automatic logic [15:0] mask_of(input int e);
    return (e < 3) ? 16'hffff : 16'h001f;
  endfunction
  // Pull output of an entry
  function automatic logic pull_of(input int e);
    case (e)
      0: return pull6;
      1: return pull7;
      2: return pullck;
      3: return pull14;
      4: return pull15;
      13: return pull24;
      default: return pullser[e-5];
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t flag %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, sampled at the ready edge
  task automatic apb(input logic w, input logic [17:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait for ready; only the hang guard ends a stuck wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read an entry and compare
  task automatic rd_check(input int e, input logic [15:0] exp);
    apb(1'b0, {idx_of(e), 2'b00}, 32'h0);
    check_word(rd, {16'h0, exp});
    check_flag(err, 1'b0);
  endtask

  // Compare the pad outputs of an entry
  task automatic check_pads(input int e, input logic [15:0] exp);
    check_word({30'h0, pad_slew_code[e]}, {30'h0, exp[3:2]});
    check_word({30'h0, pad_drive_code[e]}, {30'h0, exp[1:0]});
    check_word({31'h0, pull_of(e)}, {31'h0, exp[4]});
  endtask

  // Closing report
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(82585));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Defaults after reset
    for (int e = 0; e < 14; e++) begin
      rd_check(e, rst_of(e));
      check_pads(e, rst_of(e));
    end
    apb(1'b0, {16'hf890, 2'b00}, 32'h0);
    check_word(rd, 32'h1);
    // Random words, read back, reserved bits
    for (int e = 0; e < 14; e++) begin
      wd = $urandom;
      apb(1'b1, {idx_of(e), 2'b00}, wd);
      @(posedge pclk);
      check_pads(e, wd[15:0] & mask_of(e));
      rd_check(e, wd[15:0] & mask_of(e));
    end
    // Every slew, drive and pull setting
    for (int c = 0; c < 32; c++) begin
      apb(1'b1, {idx_of(8), 2'b00}, {27'h0, 5'(c)});
      @(posedge pclk);
      check_pads(8, 16'(c));
    end
    // Unmapped and misaligned places
    apb(1'b1, {16'hf7a4, 2'b00}, 32'hffff);
    check_flag(err, 1'b1);
    apb(1'b0, {16'hf7b9, 2'b00}, 32'h0);
    check_flag(err, 1'b1);
    check_word(rd, 32'h0);
    apb(1'b0, {idx_of(1), 2'b01}, 32'h0);
    check_flag(err, 1'b1);
    // Soft reset restores and holds defaults
    apb(1'b0, {16'hf890, 2'b00}, 32'h0);
    check_word(rd, 32'h1);
    apb(1'b1, {16'hf890, 2'b00}, 32'h0);
    repeat (2) @(posedge pclk);
    for (int e = 0; e < 14; e++) check_pads(e, rst_of(e));
    apb(1'b1, {idx_of(1), 2'b00}, 32'h0003);
    rd_check(1, rst_of(1));
    rd_check(2, rst_of(2));
    apb(1'b0, {16'hf890, 2'b00}, 32'h0);
    check_word(rd, 32'h0);
    apb(1'b1, {16'hf890, 2'b00}, 32'h1);
    for (int e = 0; e < 14; e++) rd_check(e, rst_of(e));
    // Hardware reset in mid-run
    apb(1'b1, {idx_of(13), 2'b00}, 32'h0007);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_check(13, 16'h0018);
    check_pads(13, 16'h0018);
    end_of_test();
  end
endmodule

`default_nettype wire
